// ==== include/hwm_pkg.sv ====
// Constants and shared types of the hardware monitor control core
package hwm_pkg;
  // Serial slave address
  localparam logic [4:0] HWM_ADDR_HIGH = 5'h0B;
  localparam logic [1:0] HWM_STRAP_GND = 2'h0;
  localparam logic [1:0] HWM_STRAP_VCC = 2'h1;
  localparam logic [1:0] HWM_STRAP_OPEN = 2'h2;
  // Address spaces
  localparam logic [15:0] HWM_RAM_LAST = 16'h006F;
  localparam logic [15:0] HWM_EE_FIRST = 16'h8000;
  localparam logic [15:0] HWM_EE_LAST = 16'h9FFF;
  localparam int HWM_RAM_WORDS = 112;
  localparam int HWM_EE_ADDR_W = 13;
  localparam int HWM_NUM_CH = 8;
  localparam int HWM_NUM_FAN = 8;
  // Register offsets
  localparam logic [7:0] HWM_REG_CONFIG = 8'h00;
  localparam logic [7:0] HWM_REG_TACH_CFG = 8'h01;
  localparam logic [7:0] HWM_REG_GPIO_DIR = 8'h02;
  localparam logic [7:0] HWM_REG_GPIO_OUT = 8'h03;
  localparam logic [7:0] HWM_REG_GPIO_IN = 8'h04;
  localparam logic [7:0] HWM_REG_EE_MODE = 8'h05;
  localparam logic [7:0] HWM_REG_PWM = 8'h06;
  localparam logic [7:0] HWM_REG_DAC = 8'h07;
  localparam logic [7:0] HWM_REG_STATUS_AN = 8'h08;
  localparam logic [7:0] HWM_REG_MASK_AN = 8'h09;
  localparam logic [7:0] HWM_REG_STATUS_FAN = 8'h0A;
  localparam logic [7:0] HWM_REG_MASK_FAN = 8'h0B;
  localparam logic [7:0] HWM_REG_INTRUSION = 8'h0C;
  localparam logic [7:0] HWM_REG_VALUE_BASE = 8'h20;
  localparam logic [7:0] HWM_REG_HIGH_BASE = 8'h30;
  localparam logic [7:0] HWM_REG_LOW_BASE = 8'h40;
  localparam logic [7:0] HWM_REG_FAN_BASE = 8'h50;
  localparam logic [7:0] HWM_REG_FAN_LIM_BASE = 8'h58;
  // Field positions
  localparam int HWM_CFG_START = 0;
  localparam int HWM_CFG_TEMP2_ANALOG = 1;
  localparam int HWM_EE_MODE_READ = 0;
  localparam int HWM_EE_MODE_PROG = 1;
  localparam int HWM_EE_MODE_ERASE = 2;
  localparam int HWM_EE_MODE_WPROT = 3;
  localparam int HWM_INTRUSION_BIT = 0;
  // Reset values
  localparam logic [7:0] HWM_ZERO_RESET = 8'h00;
  localparam logic [7:0] HWM_HIGH_LIMIT_RESET = 8'hFF;
  localparam logic [7:0] HWM_PWM_RESET = 8'hFF;
  // Timing
  localparam int HWM_CLK_HZ = 20_000_000;
  localparam int HWM_RESET_PULSE_MS = 180;
  localparam int HWM_RESET_PULSE_CYC = HWM_CLK_HZ / 1000 * HWM_RESET_PULSE_MS;
  localparam int HWM_PWM_HZ = 75;
  localparam int HWM_PWM_STEPS = 256;
  localparam int HWM_PWM_STEP_CYC =
    HWM_CLK_HZ / (HWM_PWM_HZ * HWM_PWM_STEPS);
  localparam int HWM_TACH_GATE_MS = 100;
  localparam int HWM_TACH_GATE_CYC = HWM_CLK_HZ / 1000 * HWM_TACH_GATE_MS;
  // Word passed from the link side to the core side
  typedef struct packed {
    logic isData;
    logic [15:0] ptr;
    logic [7:0] data;
  } hwm_evt_t;
  typedef enum logic [1:0] {HWM_EE_NONE, HWM_EE_READ, HWM_EE_PROG,
    HWM_EE_ERASE} hwm_eeop_t;
  typedef enum logic [0:0] {HWM_MEAS_IDLE, HWM_MEAS_WAIT} hwm_meas_t;
endpackage : hwm_pkg

// ==== design/hwm_core.sv ====
// Hardware monitor control core: serial slave, registers, monitoring, drives
`timescale 1ns/1ps
module hwm_core #(
  parameter int RESET_PULSE_CYC = hwm_pkg::HWM_RESET_PULSE_CYC,
  parameter int TACH_GATE_CYC = hwm_pkg::HWM_TACH_GATE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic batteryResetn,
  input wire logic linkClk,
  input wire logic linkFrame,
  input wire logic linkSdaIn,
  output logic linkSdaOut,
  output logic linkSdaOe,
  input wire logic strapPullUpSense,
  input wire logic strapPullDownSense,
  output logic adcStart,
  output logic [2:0] adcChannel,
  input wire logic adcDone,
  input wire logic [7:0] adcResult,
  output logic temp2AsAnalog,
  input wire logic [7:0] tachPinIn,
  output logic [7:0] tachPinOut,
  output logic [7:0] tachPinOe,
  input wire logic chassisIntrusionIn,
  output logic intrusionFlag,
  output logic monitorIrq,
  input wire logic mainSupplyLow,
  input wire logic standbySupplyLow,
  input wire logic mainSupplyResetIn,
  output logic mainSupplyResetOut,
  output logic mainSupplyResetOe,
  output logic standbySupplyResetN,
  output logic pwmFanOut,
  output logic pwmFanOe,
  output logic [7:0] dacCode,
  output logic eeReq,
  output hwm_pkg::hwm_eeop_t eeOp,
  output logic [12:0] eeAddr,
  output logic [7:0] eeWData,
  input wire logic [7:0] eeRData,
  input wire logic eeBlank
);
  import hwm_pkg::*;

  // Link state that lives for one frame only
  typedef struct packed {
    logic [3:0] bitCnt;
    logic [1:0] byteCnt;
    logic [7:0] shift;
    logic sel;
    logic rd;
    logic ptrLow;
    logic sdaOe;
    logic [7:0] tx;
  } hwm_lnkf_t;
  // Link state that survives between frames
  typedef struct packed {
    logic locked;
    logic [1:0] lowBits;
    logic [15:0] ptr;
    logic evtTog;
    hwm_evt_t evt;
    logic [1:0] strap1;
    logic [1:0] strap2;
    logic [3:0] eeM1;
    logic [3:0] eeM2;
    logic rdTog1;
    logic rdTog2;
    logic rdTog3;
    logic [7:0] rdCopy;
    logic rdAck;
  } hwm_lnkp_t;
  // Core state on the system clock
  typedef struct packed {
    logic [HWM_RAM_WORDS-1:0][7:0] ram;
    logic [15:0] ptr;
    logic [7:0] readHold;
    logic rdTog;
    logic rdAck1, rdAck2;
    logic evt1, evt2, evt3;
    hwm_meas_t meas;
    logic [2:0] measCh;
    logic adcStart;
    logic [7:0] tach1, tach2, tachPrev, tachOe;
    logic [HWM_NUM_FAN-1:0][7:0] tachCnt;
    logic [31:0] gateCnt;
    logic [10:0] pwmPre;
    logic [7:0] pwmPhase;
    logic pwmOe;
    logic irq;
    logic mainLow1, mainLow2, stbyLow1, stbyLow2, ext1, ext2;
    logic [31:0] mainCnt, stbyCnt;
    logic mainOe, stbyRstN;
    logic [2:0] ownDrive;
    logic intr1, intr2, intrClr;
    hwm_eeop_t eePend, eeOp;
    logic eeReq, eeCap;
    logic [12:0] eeAddr;
    logic [7:0] eeWData, eeRdData;
  } hwm_core_t;

  hwm_lnkf_t lf, lfNext;
  hwm_lnkp_t lp, lpNext;
  hwm_core_t c, cNext;
  logic intrusion_reg;

  // Volatile register reset image: limits open, fan at full speed
  function automatic logic [HWM_RAM_WORDS-1:0][7:0] ramInit();
    logic [HWM_RAM_WORDS-1:0][7:0] r;
    r = '0;
    for (int i = 0; i < HWM_NUM_CH; i++) begin
      r[HWM_REG_HIGH_BASE + 8'(i)] = HWM_HIGH_LIMIT_RESET;
    end
    r[HWM_REG_PWM] = HWM_PWM_RESET;
    return r;
  endfunction : ramInit

  function automatic logic isEe(input logic [15:0] a);
    return (a >= HWM_EE_FIRST) && (a <= HWM_EE_LAST);
  endfunction : isEe

  // Link side, clocked by the serial clock
  always_comb begin
    logic [7:0] byteIn;
    logic [1:0] strapLow;
    logic match, modeOk, eeHere, ok;
    lfNext = lf;
    lpNext = lp;
    byteIn = {lf.shift[6:0], linkSdaIn};
    // Strap pins: ground reads 0/0, supply 1/1, open 1/0
    strapLow = lp.strap2 == 2'h3 ? HWM_STRAP_VCC :
      (lp.strap2 == 2'h2 ? HWM_STRAP_OPEN : HWM_STRAP_GND);
    match = byteIn[7:3] == HWM_ADDR_HIGH &&
      byteIn[2:1] == (lp.locked ? lp.lowBits : strapLow);
    modeOk = $onehot(lp.eeM2[2:0]);
    eeHere = isEe(lp.ptr);
    ok = 1'b0;
    lpNext.strap1 = {strapPullUpSense, strapPullDownSense};
    lpNext.strap2 = lp.strap1;
    lpNext.eeM1 = c.ram[HWM_REG_EE_MODE][3:0];
    lpNext.eeM2 = lp.eeM1;
    lpNext.rdTog1 = c.rdTog;
    lpNext.rdTog2 = lp.rdTog1;
    lpNext.rdTog3 = lp.rdTog2;
    // Hold word is stable from the core's toggle until our echo
    if (lp.rdTog2 != lp.rdTog3) begin
      lpNext.rdCopy = c.readHold;
      lpNext.rdAck = lp.rdTog2;
    end
    case (lf.bitCnt)
      4'h7: begin
        lfNext.bitCnt = 4'h8;
        lfNext.sdaOe = 1'b0;
        lfNext.shift = byteIn;
        if (lf.rd) begin
          lfNext.sdaOe = 1'b0; // Release for the master's answer
        end else if (lf.byteCnt == 2'h0) begin
          // Read of nonvolatile space needs read mode alone
          ok = match && (!byteIn[0] || !eeHere ||
            (modeOk && lp.eeM2[HWM_EE_MODE_READ]));
          lfNext.sel = ok;
          lfNext.rd = ok & byteIn[0];
          lfNext.sdaOe = ok;
          if (match && !lp.locked) begin
            lpNext.locked = 1'b1;
            lpNext.lowBits = strapLow;
          end
        end else if (lf.sel && (lf.byteCnt == 2'h1 || lf.ptrLow)) begin
          // Pointer bytes are taken whatever the mode bits say
          if (lf.ptrLow) begin
            lpNext.ptr[7:0] = byteIn;
            lfNext.ptrLow = 1'b0;
          end else begin
            lpNext.ptr = {8'h00, byteIn};
            if (byteIn[7]) begin
              lpNext.ptr = {byteIn, 8'h00};
              lfNext.ptrLow = 1'b1;
            end
          end
          lpNext.evt = '{isData: 1'b0, ptr: lpNext.ptr, data: 8'h00};
          lpNext.evtTog = ~lp.evtTog;
          lfNext.sdaOe = 1'b1;
        end else if (lf.sel) begin
          ok = !eeHere || (modeOk && !lp.eeM2[HWM_EE_MODE_WPROT] &&
            !lp.eeM2[HWM_EE_MODE_READ]);
          if (ok) begin
            lpNext.evt = '{isData: 1'b1, ptr: lp.ptr, data: byteIn};
            lpNext.evtTog = ~lp.evtTog;
            lpNext.ptr = lp.ptr + 16'h0001;
          end
          lfNext.sdaOe = ok;
        end
      end
      4'h8: begin
        lfNext.bitCnt = 4'h0;
        lfNext.sdaOe = 1'b0;
        if (lf.byteCnt != 2'h3) begin
          lfNext.byteCnt = lf.byteCnt + 2'h1;
        end
        // First read byte after the address, then while acknowledged
        if (lf.sel && lf.rd && (lf.byteCnt == 2'h0 || !linkSdaIn)) begin
          lfNext.sdaOe = ~lp.rdCopy[7];
          lfNext.tx = {lp.rdCopy[6:0], 1'b0};
        end else if (lf.rd) begin
          lfNext.sel = 1'b0;
        end
      end
      default: begin
        lfNext.bitCnt = lf.bitCnt + 4'h1;
        lfNext.shift = byteIn;
        if (lf.sel && lf.rd && lf.byteCnt != 2'h0) begin
          lfNext.sdaOe = ~lf.tx[7];
          lfNext.tx = {lf.tx[6:0], 1'b0};
        end
      end
    endcase
  end

  // Frame state is cleared by the frame's own end, as the clock stops
  always_ff @(posedge linkClk or negedge linkFrame) begin
    if (!linkFrame) begin
      lf <= '0;
    end else begin
      lf <= lfNext;
    end
  end

  always_ff @(posedge linkClk or negedge resetn) begin
    if (!resetn) begin
      lp <= '0;
    end else begin
      lp <= lpNext;
    end
  end

  // Core side, on the system clock
  always_comb begin
    logic [7:0] rdVal;
    logic [6:0] idx;
    logic [7:0] res;
    logic extLow;
    rdVal = 8'h00;
    extLow = 1'b0;
    cNext = c;
    res = adcResult;
    idx = c.ptr[6:0];
    // Synchronisers
    cNext.evt1 = lp.evtTog;
    cNext.evt2 = c.evt1;
    cNext.evt3 = c.evt2;
    cNext.rdAck1 = lp.rdAck;
    cNext.rdAck2 = c.rdAck1;
    cNext.tach1 = tachPinIn;
    cNext.tach2 = c.tach1;
    cNext.tachPrev = c.tach2;
    cNext.mainLow1 = mainSupplyLow;
    cNext.mainLow2 = c.mainLow1;
    cNext.stbyLow1 = standbySupplyLow;
    cNext.stbyLow2 = c.stbyLow1;
    cNext.ext1 = mainSupplyResetIn;
    cNext.ext2 = c.ext1;
    cNext.intr1 = chassisIntrusionIn;
    cNext.intr2 = c.intr1;
    cNext.adcStart = 1'b0;
    cNext.eeReq = 1'b0;
    cNext.intrClr = 1'b0;
    cNext.eeCap = 1'b0;
    // Nonvolatile access: address settles one cycle before the request
    if (c.eeCap) begin
      cNext.eeRdData = eeRData;
    end
    if (c.eePend != HWM_EE_NONE) begin
      cNext.eeOp = c.eePend;
      cNext.eeReq = c.eePend != HWM_EE_PROG || eeBlank;
      cNext.eeCap = c.eePend == HWM_EE_READ;
      cNext.eePend = HWM_EE_NONE;
    end
    // Word from the link, stable once its toggle has crossed
    if (c.evt2 != c.evt3) begin
      cNext.ptr = lp.evt.ptr;
      cNext.eeAddr = lp.evt.ptr[HWM_EE_ADDR_W-1:0];
      cNext.eeWData = lp.evt.data;
      if (isEe(lp.evt.ptr)) begin
        if (!lp.evt.isData) begin
          cNext.eePend = c.ram[HWM_REG_EE_MODE][HWM_EE_MODE_READ] ?
            HWM_EE_READ : HWM_EE_NONE;
        end else begin
          cNext.eePend = c.ram[HWM_REG_EE_MODE][HWM_EE_MODE_ERASE] ?
            HWM_EE_ERASE : HWM_EE_PROG;
        end
      end else if (lp.evt.isData && lp.evt.ptr <= HWM_RAM_LAST) begin
        idx = lp.evt.ptr[6:0];
        case (8'(idx))
          HWM_REG_STATUS_AN, HWM_REG_STATUS_FAN: begin
            cNext.ram[idx] = c.ram[idx] & ~lp.evt.data; // Write 1 clears
          end
          HWM_REG_GPIO_IN: begin
            cNext.ram[idx] = c.ram[idx]; // Read only
          end
          HWM_REG_INTRUSION: begin
            cNext.intrClr = lp.evt.data[HWM_INTRUSION_BIT];
          end
          default: begin
            cNext.ram[idx] = lp.evt.data;
          end
        endcase
      end
    end
    // Measurement sequence over the analog channels
    case (c.meas)
      HWM_MEAS_IDLE: begin
        if (c.ram[HWM_REG_CONFIG][HWM_CFG_START]) begin
          cNext.adcStart = 1'b1;
          cNext.meas = HWM_MEAS_WAIT;
        end
      end
      HWM_MEAS_WAIT: begin
        if (adcDone) begin
          cNext.ram[HWM_REG_VALUE_BASE + 8'(c.measCh)] = res;
          if (res > c.ram[HWM_REG_HIGH_BASE + 8'(c.measCh)] ||
              res < c.ram[HWM_REG_LOW_BASE + 8'(c.measCh)]) begin
            cNext.ram[HWM_REG_STATUS_AN][c.measCh] = 1'b1;
          end
          cNext.measCh = c.measCh + 3'h1;
          cNext.meas = HWM_MEAS_IDLE;
        end
      end
      default: cNext.meas = HWM_MEAS_IDLE;
    endcase
    // Tach pulses counted over a gate, independent of the sequence
    cNext.gateCnt = c.gateCnt + 32'h1;
    for (int i = 0; i < HWM_NUM_FAN; i++) begin
      if (c.tach2[i] && !c.tachPrev[i] && c.tachCnt[i] != 8'hFF) begin
        cNext.tachCnt[i] = c.tachCnt[i] + 8'h1;
      end
      if (c.gateCnt == 32'(TACH_GATE_CYC - 1)) begin
        cNext.tachCnt[i] = 8'h00;
        cNext.ram[HWM_REG_FAN_BASE + 8'(i)] = c.tachCnt[i];
        if (!c.ram[HWM_REG_TACH_CFG][i] &&
            c.tachCnt[i] < c.ram[HWM_REG_FAN_LIM_BASE + 8'(i)]) begin
          cNext.ram[HWM_REG_STATUS_FAN][i] = 1'b1;
        end
      end
      // GPIO mode drives low only; tach mode never drives
      cNext.tachOe[i] = c.ram[HWM_REG_TACH_CFG][i] &&
        c.ram[HWM_REG_GPIO_DIR][i] && !c.ram[HWM_REG_GPIO_OUT][i];
    end
    if (c.gateCnt == 32'(TACH_GATE_CYC - 1)) begin
      cNext.gateCnt = 32'h0;
    end
    // Masked interrupt level, held while an unmasked bit stays set
    cNext.irq = |(c.ram[HWM_REG_STATUS_AN] & ~c.ram[HWM_REG_MASK_AN]) ||
      |(c.ram[HWM_REG_STATUS_FAN] & ~c.ram[HWM_REG_MASK_FAN]);
    // PWM at 256 steps per period; low drive once phase reaches duty
    cNext.pwmPre = c.pwmPre + 11'h1;
    if (c.pwmPre == 11'(HWM_PWM_STEP_CYC - 1)) begin
      cNext.pwmPre = 11'h0;
      cNext.pwmPhase = c.pwmPhase + 8'h1;
    end
    cNext.pwmOe = c.pwmPhase >= c.ram[HWM_REG_PWM];
    // Supply reset pulses restart while the supply is low
    cNext.mainCnt = c.mainLow2 ? 32'(RESET_PULSE_CYC) :
      (c.mainCnt != 32'h0 ? c.mainCnt - 32'h1 : 32'h0);
    cNext.stbyCnt = c.stbyLow2 ? 32'(RESET_PULSE_CYC) :
      (c.stbyCnt != 32'h0 ? c.stbyCnt - 32'h1 : 32'h0);
    cNext.mainOe = c.mainLow2 || c.mainCnt != 32'h0;
    cNext.stbyRstN = !(c.stbyLow2 || c.stbyCnt != 32'h0);
    cNext.ownDrive = {c.ownDrive[1:0], c.mainOe};
    // Our own drive echoes back through the synchroniser; ignore it
    extLow = !c.ext2 && !c.mainOe && c.ownDrive == 3'h0;
    if (extLow) begin
      cNext.ram = ramInit();
      cNext.meas = HWM_MEAS_IDLE;
      cNext.measCh = 3'h0;
      cNext.irq = 1'b0;
      cNext.eePend = HWM_EE_NONE;
    end
    cNext.ram[HWM_REG_GPIO_IN] = c.tach2;
    // Hold word for the link; refreshed only after the last was echoed
    if (isEe(c.ptr)) begin
      rdVal = c.eeRdData;
    end else if (c.ptr > HWM_RAM_LAST) begin
      rdVal = 8'h00;
    end else if (8'(idx) == HWM_REG_INTRUSION) begin
      rdVal = {7'h00, intrusion_reg};
    end else begin
      rdVal = c.ram[c.ptr[6:0]];
    end
    if (c.rdTog == c.rdAck2 && rdVal != c.readHold) begin
      cNext.readHold = rdVal;
      cNext.rdTog = ~c.rdTog;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      c <= '{ram: ramInit(), meas: HWM_MEAS_IDLE, eePend: HWM_EE_NONE,
        eeOp: HWM_EE_NONE, mainCnt: 32'(RESET_PULSE_CYC),
        stbyCnt: 32'(RESET_PULSE_CYC), mainOe: 1'b1, ext1: 1'b1,
        ext2: 1'b1, default: '0};
    end else begin
      c <= cNext;
    end
  end

  // Kept on the backup supply domain; the set wins over a clear
  always_ff @(posedge clk or negedge batteryResetn) begin
    if (!batteryResetn) begin
      intrusion_reg <= 1'b0;
    end else if (c.intr2) begin
      intrusion_reg <= 1'b1;
    end else if (c.intrClr) begin
      intrusion_reg <= 1'b0;
    end
  end

  // Open-drain pins only ever pull low
  assign linkSdaOut = 1'b0;
  assign linkSdaOe = lf.sdaOe;
  assign adcStart = c.adcStart;
  assign adcChannel = c.measCh;
  assign temp2AsAnalog = c.ram[HWM_REG_CONFIG][HWM_CFG_TEMP2_ANALOG];
  assign tachPinOut = 8'h00;
  assign tachPinOe = c.tachOe;
  assign intrusionFlag = intrusion_reg;
  assign monitorIrq = c.irq;
  assign mainSupplyResetOut = 1'b0;
  assign mainSupplyResetOe = c.mainOe;
  assign standbySupplyResetN = c.stbyRstN;
  assign pwmFanOut = 1'b0;
  assign pwmFanOe = c.pwmOe;
  assign dacCode = c.ram[HWM_REG_DAC];
  assign eeReq = c.eeReq;
  assign eeOp = c.eeOp;
  assign eeAddr = c.eeAddr;
  assign eeWData = c.eeWData;
endmodule : hwm_core

// ==== bench/hwm_host_model.sv ====
// Serial bus host master model driving the link side of the core
`timescale 1ns/1ps
module hwm_host_model (
  output logic linkClk,
  output logic linkFrame,
  output logic linkSdaIn,
  input wire logic linkSdaOe
);
  logic hostSda;
  // Pull-up wire: high unless either party pulls low
  assign linkSdaIn = hostSda & ~linkSdaOe;
  // Clock stands still low outside frames
  initial begin
    linkClk = 1'b0;
    linkFrame = 1'b0;
    hostSda = 1'b1;
  end
  // One bit: data set in low phase, sampled just before the rise
  task automatic bit9(input logic d, output logic s);
    hostSda = d;
    #31 s = linkSdaIn;
    #1 linkClk = 1'b1;
    #32 linkClk = 1'b0;
  endtask : bit9
  // Whole frame, bytes MSB first; read frames release SDA and end with NACK
  task automatic txn(input logic [31:0] b, input int n,
    output logic [7:0] rd, output logic [3:0] ak);
    logic s;
    logic rdMode;
    rdMode = b[24];
    ak = 4'h0;
    linkFrame = 1'b1;
    #40;
    for (int i = 0; i < n; i++) begin
      for (int j = 7; j >= 0; j--) begin
        bit9((rdMode && i > 0) ? 1'b1 : b[31], s);
        rd[j] = s;
        b = {b[30:0], 1'b0};
      end
      // Released on the core's acks; only a middle read byte is acked by us
      bit9(!(rdMode && i > 0 && i < n - 1), s);
      ak[i] = !s;
    end
    hostSda = 1'b1;
    #40 linkFrame = 1'b0;
    #700; // Lets the pointer word cross before a following read
  endtask : txn
endmodule : hwm_host_model

// ==== bench/hwm_core_sva.sv ====
// Port-level assertions of the monitor core
`timescale 1ns/1ps
module hwm_core_sva #(
  parameter int RESET_PULSE_CYC = 20
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic standbySupplyLow,
  input wire logic standbySupplyResetN,
  input wire logic mainSupplyResetOe,
  input wire logic mainSupplyResetOut,
  input wire logic linkSdaOut,
  input wire logic pwmFanOut,
  input wire logic [7:0] tachPinOut,
  input wire logic linkFrame,
  input wire logic linkSdaOe,
  input wire logic eeReq,
  input hwm_pkg::hwm_eeop_t eeOp,
  input wire logic eeBlank,
  input wire logic adcStart,
  input wire logic [2:0] adcChannel,
  input wire logic chassisIntrusionIn,
  input wire logic intrusionFlag
);
  import hwm_pkg::*;
  int unsigned upCnt;
  logic [2:0] lastCh;
  logic seenStart;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Cycles since reset release, saturating past the pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upCnt <= 0;
    end else if (upCnt < RESET_PULSE_CYC + 9) begin
      upCnt <= upCnt + 1;
    end
  end
  // Last converted channel, to check the stepping order
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lastCh <= 3'h0;
      seenStart <= 1'b0;
    end else if (adcStart) begin
      lastCh <= adcChannel;
      seenStart <= 1'b1;
    end
  end
  a_rst_pulse_held: assert property (upCnt < RESET_PULSE_CYC |->
    !standbySupplyResetN && mainSupplyResetOe)
    else $error("reset outputs released during power-up pulse");
  a_rst_pulse_ends: assert property (
    upCnt == RESET_PULSE_CYC + 8 && !standbySupplyLow |-> standbySupplyResetN)
    else $error("standby reset still low after pulse");
  a_open_drain_low: assert property (!linkSdaOut && !pwmFanOut &&
    !mainSupplyResetOut && tachPinOut == 8'h00)
    else $error("open-drain pin driven high");
  a_sda_idle: assert property (!linkFrame [*2] |-> !linkSdaOe)
    else $error("SDA pulled outside a frame");
  a_ee_op_valid: assert property (eeReq |-> eeOp != HWM_EE_NONE)
    else $error("memory request without an operation");
  a_ee_prog_blank: assert property (
    eeReq && eeOp == HWM_EE_PROG |-> eeBlank)
    else $error("program of a location that is not blank");
  a_ee_req_pulse: assert property (eeReq |=> !eeReq)
    else $error("memory request longer than one cycle");
  a_adc_start_pulse: assert property (adcStart |=> !adcStart)
    else $error("conversion start longer than one cycle");
  a_adc_sequence: assert property (adcStart && seenStart |->
    adcChannel == lastCh + 3'h1)
    else $error("channel out of sequence");
  a_intr_sets: assert property (
    chassisIntrusionIn [*4] |-> ##[0:2] intrusionFlag)
    else $error("intrusion not latched");
  c_conversion: cover property (adcStart);
  c_ee_program: cover property (eeReq && eeOp == HWM_EE_PROG);
  c_intrusion: cover property ($rose(intrusionFlag));
endmodule : hwm_core_sva
bind hwm_core hwm_core_sva #(.RESET_PULSE_CYC(RESET_PULSE_CYC)) i_hwm_core_sva (
  .clk, .resetn, .standbySupplyLow, .standbySupplyResetN, .mainSupplyResetOe,
  .mainSupplyResetOut, .linkSdaOut, .pwmFanOut, .tachPinOut, .linkFrame,
  .linkSdaOe, .eeReq, .eeOp, .eeBlank, .adcStart, .adcChannel,
  .chassisIntrusionIn, .intrusionFlag
);

// ==== bench/test_hwm_core.sv ====
// Self-checking bench of the monitor core with a serial host model
`timescale 1ns/1ps
module test_hwm_core;
  import hwm_pkg::*;
  localparam int RST_CYC = 20;
  logic clk = 1'b0, resetn = 1'b0, batteryResetn = 1'b0, extRstn = 1'b1;
  logic linkClk, linkFrame, linkSdaIn, linkSdaOut, linkSdaOe;
  logic strapPullUpSense = 1'b1, strapPullDownSense = 1'b0;
  logic adcStart, adcDone = 1'b0, temp2AsAnalog, chassisIntrusionIn = 1'b0;
  logic [2:0] adcChannel;
  logic [7:0] adcResult = 8'h10, tachPinIn, tachPinOut, tachPinOe;
  logic intrusionFlag, monitorIrq, mainSupplyLow = 1'b0;
  logic standbySupplyLow = 1'b0, mainSupplyResetIn, mainSupplyResetOut;
  logic mainSupplyResetOe, standbySupplyResetN, pwmFanOut, pwmFanOe;
  logic [7:0] dacCode, eeWData, eeRData = 8'h00, rdv, devAddr = 8'h5C;
  logic eeReq, eeBlank = 1'b1;
  hwm_eeop_t eeOp;
  logic [12:0] eeAddr, lastAddr = 13'h0;
  logic [1:0] lastOp = 2'h0;
  logic [3:0] ak;
  int num_errors = 0, checked = 0, reqCnt = 0;
  always #25 clk = ~clk;
  // Released pins read high through their pull-ups
  assign tachPinIn = ~tachPinOe;
  assign mainSupplyResetIn = ~mainSupplyResetOe & extRstn;
  // Converter answers each start one cycle later
  always @(negedge clk) adcDone <= adcStart;
  // Memory request log
  always @(posedge clk) begin
    if (eeReq === 1'b1) begin
      reqCnt++;
      lastAddr = eeAddr;
      lastOp = eeOp;
    end
  end
  hwm_core #(.RESET_PULSE_CYC(RST_CYC), .TACH_GATE_CYC(50)) i_hwm_core (
    .clk, .resetn, .batteryResetn, .linkClk, .linkFrame, .linkSdaIn,
    .linkSdaOut, .linkSdaOe, .strapPullUpSense, .strapPullDownSense,
    .adcStart, .adcChannel, .adcDone, .adcResult, .temp2AsAnalog, .tachPinIn,
    .tachPinOut, .tachPinOe, .chassisIntrusionIn, .intrusionFlag, .monitorIrq,
    .mainSupplyLow, .standbySupplyLow, .mainSupplyResetIn, .mainSupplyResetOut,
    .mainSupplyResetOe, .standbySupplyResetN, .pwmFanOut, .pwmFanOe, .dacCode,
    .eeReq, .eeOp, .eeAddr, .eeWData, .eeRData, .eeBlank
  );
  hwm_host_model i_hwm_host_model (.linkClk, .linkFrame, .linkSdaIn,
    .linkSdaOe);
  task automatic chk(input string nm, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // Register address always leads a write
  task automatic wr(input logic [7:0] r, d);
    i_hwm_host_model.txn({devAddr, r, d, 8'h00}, 3, rdv, ak);
  endtask : wr
  task automatic rd(input logic [7:0] r);
    i_hwm_host_model.txn({devAddr, r, 16'h0}, 2, rdv, ak);
    i_hwm_host_model.txn({devAddr | 8'h01, 24'h0}, 2, rdv, ak);
  endtask : rd
  task automatic do_reset;
    @(negedge clk);
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    chk("standby reset in pulse", 16'h0, standbySupplyResetN);
    chk("main reset in pulse", 16'h1, mainSupplyResetOe);
    repeat (RST_CYC + 10) @(negedge clk);
    chk("standby reset after", 16'h1, standbySupplyResetN);
    chk("main reset after", 16'h0, mainSupplyResetOe);
  endtask : do_reset
  // Each strap level after its own reset; later strap changes ignored
  task automatic t_address;
    logic [7:0] adr [3];
    logic [1:0] sns [3];
    adr = '{8'h58, 8'h5A, 8'h5C};
    sns = '{2'b00, 2'b11, 2'b10};
    for (int k = 0; k < 3; k++) begin
      {strapPullUpSense, strapPullDownSense} = sns[k];
      do_reset();
      devAddr = adr[(k + 1) % 3];
      wr(HWM_REG_DAC, 8'h11);
      chk("foreign address", 16'h0, ak);
      devAddr = adr[k];
      wr(HWM_REG_DAC, 8'hA5);
      chk("strap address", 16'h7, ak);
      @(negedge clk);
      {strapPullUpSense, strapPullDownSense} = sns[(k + 1) % 3];
      wr(HWM_REG_DAC, 8'h5A);
      chk("locked address", 16'h7, ak);
      chk("dac code", 16'h5A, dacCode);
    end
  endtask : t_address
  // Read back, then external low on the main reset pin
  task automatic t_regs;
    rd(HWM_REG_DAC);
    chk("read back", 16'h5A, rdv);
    @(negedge clk);
    extRstn = 1'b0;
    repeat (10) @(negedge clk);
    extRstn = 1'b1;
    repeat (10) @(negedge clk);
    chk("dac after pin reset", 16'h0, dacCode);
  endtask : t_regs
  task automatic t_monitor;
    wr(HWM_REG_LOW_BASE, 8'h80);
    wr(HWM_REG_CONFIG, 8'h01);
    repeat (200) @(negedge clk);
    chk("irq on low value", 16'h1, monitorIrq);
    rd(HWM_REG_VALUE_BASE);
    chk("stored value", 16'h10, rdv);
    wr(HWM_REG_MASK_AN, 8'h01);
    repeat (5) @(negedge clk);
    chk("irq masked", 16'h0, monitorIrq);
  endtask : t_monitor
  task automatic t_eeprom;
    int n;
    wr(HWM_REG_EE_MODE, 8'h03);
    i_hwm_host_model.txn(32'h5C9FFF3C, 4, rdv, ak);
    chk("two mode bits", 16'h7, ak);
    wr(HWM_REG_EE_MODE, 8'h02);
    n = reqCnt;
    i_hwm_host_model.txn(32'h5C9FFF3C, 4, rdv, ak);
    chk("program ack", 16'hF, ak);
    chk("program requests", 16'(n + 1), 16'(reqCnt));
    chk("program addr", 16'h1FFF, 16'(lastAddr));
    chk("program op", 16'(HWM_EE_PROG), 16'(lastOp));
    @(negedge clk);
    eeBlank = 1'b0;
    i_hwm_host_model.txn(32'h5C9FFF3C, 4, rdv, ak);
    chk("no program", 16'(n + 1), 16'(reqCnt));
  endtask : t_eeprom
  task automatic t_misc;
    @(negedge clk);
    chassisIntrusionIn = 1'b1;
    repeat (5) @(negedge clk);
    chassisIntrusionIn = 1'b0;
    repeat (5) @(negedge clk);
    chk("intrusion latched", 16'h1, intrusionFlag);
    wr(HWM_REG_CONFIG, 8'h02);
    chk("temp2 analog", 16'h1, temp2AsAnalog);
    wr(HWM_REG_TACH_CFG, 8'h01);
    wr(HWM_REG_GPIO_DIR, 8'h01);
    chk("gpio drive low", 16'h01, tachPinOe);
    wr(HWM_REG_PWM, 8'h00);
    repeat (3000) @(negedge clk);
    chk("pwm zero duty", 16'h1, pwmFanOe);
  endtask : t_misc
  initial begin
    repeat (3) @(negedge clk);
    batteryResetn = 1'b1;
    t_address();
    t_regs();
    t_monitor();
    t_eeprom();
    t_misc();
    give_verdict();
  end
  // Watchdog well past the expected run length
  initial begin
    #2000000;
    num_errors++;
    give_verdict();
  end
endmodule : test_hwm_core
